//--- rtl/irt_top.sv
// ir remote transmit timer with carrier, standby control and apb registers
`timescale 1ns/1ps
`include "irt_defines.svh"
module irt_top import irt_pkg::*; #(
   parameter int CW = `IRT_CNT_W
) (
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic wake_i,
   input wire logic transmit_indicator_pin_i,
   output logic transmit_indicator_pin_o,
   output logic transmit_indicator_pin_oe_o,
   output logic transmit_indicator_pd_o,
   output logic ir_carrier_out_o,
   output logic osc_pins_low_o,
   output logic end_of_count_o,
   output logic cpu_halted_o
);
   irt_clk_if bus ();
   irt_prescale u_pre (.clock_i(clock_i), .rst_i(rst_i), .bus(bus.pre));
   irt_carrier_gen u_car (.clock_i(clock_i), .rst_i(rst_i), .bus(bus.gen));

   function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
      hit = (a == o);
   endfunction

   // synchronisers
   logic [1:0] wake_s_q;
   logic [1:0] pin_s_q;
   wire logic wake_s = wake_s_q[1];
   wire logic pin_s = pin_s_q[1];

   // registers
   logic [8:0] ctrl_q;
   logic [15:0] hold_q;
   logic [CW-1:0] count_q;
   logic [CW-1:0] count_d;
   logic oe_q;
   logic oe_d;
   logic run_q;
   logic run_d;
   logic tail_q;
   logic flag_q;
   logic flag_d;
   irt_stby_t state_q;
   irt_stby_t state_d;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic ir_q;
   logic ind_q;
   logic ind_oe_q;
   logic pd_q;
   logic osc_low_q;
   logic eoc_q;
   logic halted_q;

   // bus decode
   wire logic hit_ctrl = hit(paddr_i, `IRT_OFF_CTRL);
   wire logic hit_timer = hit(paddr_i, `IRT_OFF_TIMER);
   wire logic hit_stby = hit(paddr_i, `IRT_OFF_STBY);
   wire logic hit_hold = hit(paddr_i, `IRT_OFF_HOLD);
   wire logic mapped = hit_ctrl | hit_timer | hit_stby | hit_hold;
   wire logic standby = (state_q != IRT_RUN);
   wire logic bad = ~mapped | (pwrite_i & standby);
   wire logic done = psel_i & penable_i & pready_q;
   wire logic wr_ok = done & pwrite_i & ~bad;
   wire logic load = wr_ok & hit_timer; // RULE_13
   wire logic [CW-1:0] load_cnt = pwdata_i[CW-1:0];
   wire logic load_oe = pwdata_i[`IRT_TMR_OE];
   wire logic req_halt = wr_ok & hit_stby & pwdata_i[`IRT_STBY_HALT];
   wire logic req_stop = wr_ok & hit_stby & pwdata_i[`IRT_STBY_STOP]
                         & ~req_halt;
   wire logic flag_clr = wr_ok & hit_stby & pwdata_i[`IRT_STBY_FLAG];
   wire logic cdis = ctrl_q[`IRT_CTRL_CDIS];
   wire logic led_mode = ctrl_q[`IRT_CTRL_LED];
   wire logic eoc = ~run_q & (count_q == '0); // RULE_01 RULE_04 RULE_05
   wire logic rel = req_halt ? eoc : wake_s;

   // read mux
   wire logic [31:0] rd_ctrl = {19'h00000, pin_s, 3'h0, ctrl_q};
   wire logic [31:0] rd_timer = {20'h00000, eoc, run_q, oe_q,
                                 9'(count_q)};
   wire logic [31:0] rd_stby = {27'h0000000, flag_q, 2'h0,
                                state_q == IRT_STOP, state_q == IRT_HALT};
   wire logic [31:0] rd_hold = {16'h0000, hold_q};
   wire logic [31:0] rd_mux = hit_ctrl ? rd_ctrl :
                              hit_timer ? rd_timer :
                              hit_stby ? rd_stby :
                              hit_hold ? rd_hold : 32'h00000000;

   // links to prescaler and carrier generator
   assign bus.divide = ctrl_q[`IRT_CTRL_DIV]; // RULE_03 RULE_21
   assign bus.mode = ctrl_q[1:0];
   assign bus.hold = (state_q == IRT_STOP); // RULE_14
   assign bus.restart = load;

   // timer next state
   always_comb begin
      count_d = count_q;
      oe_d = oe_q;
      run_d = run_q;
      if (state_q == IRT_STOP) begin // RULE_14
         count_d = '0;
         oe_d = 1'b0;
         run_d = 1'b0;
      end else if (load) begin // RULE_02 RULE_20
         count_d = load_cnt;
         oe_d = load_oe;
         run_d = |load_cnt;
      end else if (bus.tick & run_q) begin // RULE_15
         if (count_q == '0) begin // RULE_07
            run_d = 1'b0;
         end else begin
            count_d = count_q - 1'b1; // RULE_03
         end
      end
   end

   // carrier tail after stop
   wire logic tail_d = ~cdis & bus.carrier & (run_q | tail_q) // RULE_11
                       & ~run_d;
   wire logic ir_d = oe_q & ((run_q & (cdis | bus.carrier)) // RULE_09 RULE_22
                             | (tail_q & bus.carrier)); // RULE_10
   wire logic ind_d = ~(oe_q & run_q); // RULE_08 RULE_09

   // standby control
   always_comb begin
      state_d = state_q;
      flag_d = flag_q;
      if (flag_clr) begin
         flag_d = 1'b0;
      end
      case (state_q)
         IRT_RUN: begin
            if (req_halt | req_stop) begin
               if (flag_q) begin // RULE_17
                  flag_d = rel;
               end else if (rel) begin // RULE_19
                  flag_d = 1'b1;
               end else begin
                  state_d = req_halt ? IRT_HALT : IRT_STOP;
               end
            end
         end
         IRT_HALT: begin
            if (eoc) begin // RULE_06
               state_d = IRT_RUN;
               flag_d = 1'b1; // RULE_18
            end
         end
         IRT_STOP: begin
            if (wake_s) begin
               state_d = IRT_RUN;
               flag_d = 1'b1; // RULE_18
            end
         end
         default: begin
            state_d = IRT_RUN;
         end
      endcase
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wake_s_q <= 2'h0;
         pin_s_q <= 2'h0;
      end else begin
         wake_s_q <= {wake_s_q[0], wake_i};
         pin_s_q <= {pin_s_q[0], transmit_indicator_pin_i};
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ctrl_q <= `IRT_CTRL_RST;
         hold_q <= 16'h0000;
      end else begin
         if (wr_ok & hit_ctrl) begin
            ctrl_q <= pwdata_i[8:0];
         end
         if (wr_ok & hit_hold) begin // RULE_16
            hold_q <= pwdata_i[15:0];
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         count_q <= '0;
         oe_q <= 1'b0;
         run_q <= 1'b0;
         tail_q <= 1'b0;
         state_q <= IRT_RUN;
         flag_q <= 1'b0;
      end else begin
         count_q <= count_d;
         oe_q <= oe_d;
         run_q <= run_d;
         tail_q <= tail_d;
         state_q <= state_d;
         flag_q <= flag_d;
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= psel_i & penable_i & ~pready_q;
         if (psel_i & penable_i & ~pready_q) begin
            pslverr_q <= bad;
            prdata_q <= pwrite_i ? 32'h00000000 : rd_mux;
         end
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         ir_q <= 1'b0;
         ind_q <= 1'b1;
         ind_oe_q <= 1'b1;
         pd_q <= 1'b0;
         osc_low_q <= 1'b0;
         eoc_q <= 1'b1;
         halted_q <= 1'b0;
      end else begin
         ir_q <= ir_d;
         ind_q <= ind_d;
         ind_oe_q <= led_mode; // RULE_23
         pd_q <= ~led_mode; // RULE_23
         osc_low_q <= (state_q == IRT_STOP); // RULE_14
         eoc_q <= eoc; // RULE_04
         halted_q <= standby;
      end
   end

   assign prdata_o = prdata_q;
   assign pready_o = pready_q;
   assign pslverr_o = pslverr_q;
   assign transmit_indicator_pin_o = ind_q;
   assign transmit_indicator_pin_oe_o = ind_oe_q;
   assign transmit_indicator_pd_o = pd_q;
   assign ir_carrier_out_o = ir_q;
   assign osc_pins_low_o = osc_low_q;
   assign end_of_count_o = eoc_q;
   assign cpu_halted_o = halted_q;

   // checks
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   logic [7:0] gap_q;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         gap_q <= 8'h00;
      end else begin
         gap_q <= (bus.tick | bus.restart | bus.hold) ? 8'h00 : gap_q + 8'h01;
      end
   end

   property p_tick_gap;
      bus.tick & ~$past(bus.divide) & ~bus.divide |-> gap_q == 8'd63;
   endproperty
   a_tick_gap: assert property (p_tick_gap) // RULE_03
      else $error("tick spacing wrong");

   property p_dec;
      run_q & bus.tick & (count_q != '0) & ~load & (state_q != IRT_STOP)
         |=> count_q == $past(count_q) - 1'b1;
   endproperty
   a_dec: assert property (p_dec) // RULE_03
      else $error("count did not decrement");

   property p_load_run;
      load & (load_cnt != '0) & (state_q != IRT_STOP)
         |=> run_q && count_q == $past(load_cnt) && oe_q == $past(load_oe);
   endproperty
   a_load_run: assert property (p_load_run) // RULE_20
      else $error("load missed");

   property p_load_zero;
      load & (load_cnt == '0) |=> ~run_q ##1 end_of_count_o;
   endproperty
   a_load_zero: assert property (p_load_zero) // RULE_02
      else $error("zero load ran");

   property p_eoc_hold;
      eoc & ~load |=> eoc;
   endproperty
   a_eoc_hold: assert property (p_eoc_hold) else $error("end lost"); // RULE_05

   property p_end_step;
      run_q & (count_q == '0) & bus.tick & ~load |=> ~run_q ##1 end_of_count_o;
   endproperty
   a_end_step: assert property (p_end_step) // RULE_04
      else $error("no stop at zero");

   property p_off;
      ~oe_q |=> transmit_indicator_pin_o & ~ir_carrier_out_o;
   endproperty
   a_off: assert property (p_off) else $error("pins active"); // RULE_08

   property p_run_pins;
      oe_q & run_q & cdis |=> ~transmit_indicator_pin_o & ir_carrier_out_o;
   endproperty
   a_run_pins: assert property (p_run_pins) else $error("run pins"); // RULE_22

   property p_tail;
      oe_q & tail_q & bus.carrier |=> ir_carrier_out_o;
   endproperty
   a_tail: assert property (p_tail) else $error("tail cut"); // RULE_11

   property p_halt_exit;
      (state_q == IRT_HALT) & eoc |=> (state_q == IRT_RUN) && flag_q;
   endproperty
   a_halt_exit: assert property (p_halt_exit) // RULE_06
      else $error("halt stuck");

   property p_flag_block;
      (state_q == IRT_RUN) & flag_q & (req_halt | req_stop)
         |=> state_q == IRT_RUN;
   endproperty
   a_flag_block: assert property (p_flag_block) // RULE_17
      else $error("entered");

   property p_stop_clear;
      (state_q == IRT_STOP) ##1 (state_q == IRT_STOP)
         |-> count_q == '0 && ~run_q && osc_pins_low_o;
   endproperty
   a_stop_clear: assert property (p_stop_clear) // RULE_14
      else $error("stop dirty");

   property p_hold_keep;
      standby & done & pwrite_i |=> $stable(hold_q) && pslverr_o;
   endproperty
   a_hold_keep: assert property (p_hold_keep) // RULE_16
      else $error("hold lost");

   c_halt: cover property ((state_q == IRT_HALT) ##1 (state_q == IRT_RUN));
   c_stop: cover property ((state_q == IRT_STOP) ##1 (state_q == IRT_RUN));
   c_tail: cover property (tail_q & oe_q ##1 ~tail_q);
endmodule

//--- rtl/irt_defines.svh
// offsets, fields, reset values and timing counts of the ir remote timer
//Contract
//RULE_01: timer is a 9-bit down counter, output-enable flag, zero detector.
//RULE_02: nonzero load starts the countdown; a zero load leaves it stopped.
//RULE_03: count steps down every 64 oscillator periods, 128 with divide set.
//RULE_04: at zero the zero detector raises end-of-count and the timer stops.
//RULE_05: end-of-count stays high while the count is zero and timer stopped.
//RULE_06: end-of-count ends the timer-wait halt; execution resumes after it.
//RULE_07: timed interval equals loaded value plus one, times the tick period.
//RULE_08: pins show the timer state only while the output-enable flag is one.
//RULE_09: running: indicator low, ir on; stopped: indicator high, ir low.
//RULE_10: running ir carries the carrier only while carrier-disable is zero.
//RULE_11: a stop during carrier high keeps ir on until the carrier falls.
//RULE_12: the first carrier high pulse after start may be shortened.
//RULE_13: software makes one-tick pulses by loading nonzero then zero values.
//RULE_14: stop mode halts oscillator, holds its pins low, clears the timer.
//RULE_15: halt mode keeps oscillator, timer and both output pins working.
//RULE_16: standby keeps memory, accumulator, carry and ports unchanged.
//RULE_17: standby is entered only with status flag zero, never with it one.
//RULE_18: leaving standby sets the status flag.
//RULE_19: wake already true at halt: no standby entry, status flag set.
//RULE_20: a nonzero load while running restarts with the new value and flag.
//RULE_21: carrier osc/8, /64, /96 half or /96 third duty; divide halves it.
//RULE_22: carrier-disable set gives a steady high in place of the carrier.
//RULE_23: indicator pin drives only in output mode, its pull-down then off.
`ifndef IRT_DEFINES_SVH
`define IRT_DEFINES_SVH
`define IRT_OFF_CTRL 12'h000
`define IRT_OFF_TIMER 12'h004
`define IRT_OFF_STBY 12'h008
`define IRT_OFF_HOLD 12'h00c
`define IRT_CTRL_RST 9'h103
`define IRT_CTRL_DIV 3
`define IRT_CTRL_CDIS 2
`define IRT_CTRL_LED 8
`define IRT_CTRL_PIN 12
`define IRT_TMR_OE 9
`define IRT_TMR_RUN 10
`define IRT_TMR_EOC 11
`define IRT_STBY_HALT 0
`define IRT_STBY_STOP 1
`define IRT_STBY_FLAG 4
`define IRT_CNT_W 9
`define IRT_TICK_PERIODS 7'd64
`define IRT_CAR_FAST 9'd4
`define IRT_CAR_MID 9'd32
`define IRT_CAR_SLOW 9'd48
`define IRT_CAR_THIRD_HI 9'd32
`define IRT_CAR_THIRD_LO 9'd64
`endif

//--- rtl/irt_pkg.sv
// types of the ir remote timer
package irt_pkg;
   typedef enum logic [1:0] {IRT_RUN, IRT_HALT, IRT_STOP} irt_stby_t;
   typedef enum logic [1:0] {
      IRT_CAR_8, IRT_CAR_64, IRT_CAR_96, IRT_CAR_96_THIRD
   } irt_car_t;
endpackage

//--- rtl/irt_clk_if.sv
// signals between timer core, prescaler and carrier generator
`timescale 1ns/1ps
interface irt_clk_if;
   logic divide;
   logic hold;
   logic restart;
   logic [1:0] mode;
   logic tick;
   logic carrier;
   modport ctl (output divide, hold, restart, mode, input tick, carrier);
   modport pre (input divide, hold, restart, output tick);
   modport gen (input divide, hold, mode, output carrier);
endinterface

//--- rtl/irt_prescale.sv
// timer tick prescaler, one tick every 64 or 128 oscillator periods
`timescale 1ns/1ps
`include "irt_defines.svh"
module irt_prescale import irt_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_i,
   irt_clk_if.pre bus
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   wire logic [7:0] limit = bus.divide ? {`IRT_TICK_PERIODS, 1'b0} - 8'h01
                                     : {1'b0, `IRT_TICK_PERIODS} - 8'h01;
   assign bus.tick = (cnt_q == limit) & ~bus.hold; // RULE_03
   assign cnt_d = (bus.hold | bus.restart | bus.tick) ? 8'h00
                                                      : cnt_q + 8'h01;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
endmodule

//--- rtl/irt_carrier_gen.sv
// carrier generator, free running from the oscillator
`timescale 1ns/1ps
`include "irt_defines.svh"
module irt_carrier_gen import irt_pkg::*; (
   input wire logic clock_i,
   input wire logic rst_i,
   irt_clk_if.gen bus
);
   logic [9:0] cnt_q;
   logic car_q;
   logic [8:0] hi_base;
   logic [8:0] lo_base;
   always_comb begin
      case (irt_car_t'(bus.mode)) // RULE_21
         IRT_CAR_8: begin
            hi_base = `IRT_CAR_FAST;
            lo_base = `IRT_CAR_FAST;
         end
         IRT_CAR_64: begin
            hi_base = `IRT_CAR_MID;
            lo_base = `IRT_CAR_MID;
         end
         IRT_CAR_96: begin
            hi_base = `IRT_CAR_SLOW;
            lo_base = `IRT_CAR_SLOW;
         end
         default: begin
            hi_base = `IRT_CAR_THIRD_HI;
            lo_base = `IRT_CAR_THIRD_LO;
         end
      endcase
   end
   wire logic [8:0] base = car_q ? hi_base : lo_base;
   wire logic [9:0] len = bus.divide ? {base, 1'b0} : {1'b0, base}; // RULE_21
   wire logic flip = (cnt_q >= len - 10'h001);
   assign bus.carrier = car_q;
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         cnt_q <= 10'h000;
         car_q <= 1'b0;
      end else if (bus.hold) begin
         cnt_q <= 10'h000;
         car_q <= 1'b0;
      end else begin
         cnt_q <= flip ? 10'h000 : cnt_q + 10'h001;
         car_q <= car_q ^ flip; // RULE_12
      end
   end
endmodule

//--- bench/irt_led_model.sv
// led driver model: ir emitter and transmit indicator pin level
`timescale 1ns/1ps
module irt_led_model (
   input wire logic clock_i,
   input wire logic ir_i,
   input wire logic ind_i,
   input wire logic oe_i,
   input wire logic pd_i,
   output logic pin_o,
   output int ir_pulses_o
);
   logic last_q;
   always_ff @(posedge clock_i) begin
      if (oe_i) begin
         last_q <= ind_i;
      end
   end
   // released pin: pull-down or drifting level
   assign pin_o = oe_i ? ind_i : (pd_i ? 1'b0 : ~last_q);
   // emitter flashes counted on rising ir
   initial ir_pulses_o = 0;
   always @(posedge ir_i) ir_pulses_o++;
endmodule

//--- bench/tb_top.sv
// self-checking bench of the ir remote timer
`timescale 1ns/1ps
`include "irt_defines.svh"
module tb_top;
   logic clock_i, rst_i, psel, penable, pwrite, wake;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic pready, pslverr, err, pin, ind, ind_oe, ind_pd, ir, osc, eoc, hlt;
   int n_fail, n_checks, n, pulses;
   irt_top u_dut (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
      .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
      .pslverr_o(pslverr), .wake_i(wake), .transmit_indicator_pin_i(pin),
      .transmit_indicator_pin_o(ind), .transmit_indicator_pin_oe_o(ind_oe),
      .transmit_indicator_pd_o(ind_pd), .ir_carrier_out_o(ir),
      .osc_pins_low_o(osc), .end_of_count_o(eoc), .cpu_halted_o(hlt));
   irt_led_model u_led (.clock_i(clock_i), .ir_i(ir), .ind_i(ind),
      .oe_i(ind_oe), .pd_i(ind_pd), .pin_o(pin), .ir_pulses_o(pulses));
   initial begin
      clock_i = 0;
      forever #12.5 clock_i = ~clock_i;
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task summarize;
      $display("checks %0d fails %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // one apb transfer, held until pready
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge clock_i);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock_i);
      penable <= 1;
      k = 0;
      do begin
         @(posedge clock_i);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      if (k >= 50) n_fail++;
   endtask
   task wait_ir(input logic v, output int c);
      c = 0;
      while (ir !== v && c < 3000) begin
         @(posedge clock_i);
         c++;
      end
   endtask
   task wait_cyc(input int c);
      repeat (c) @(posedge clock_i);
   endtask
   logic [31:0] tctl[2] = '{32'h104, 32'h10c};
   logic [31:0] tld[2] = '{32'h203, 32'h202};
   int texp[2] = '{256, 384};
   int chi[5] = '{4, 32, 48, 32, 8};
   int clo[5] = '{4, 32, 48, 64, 8};
   initial begin
      n_fail = 0;
      n_checks = 0;
      rst_i = 1;
      {psel, penable, pwrite, wake} = 4'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      wait_cyc(6);
      rst_i <= 0;
      chk({ir, ind, eoc, hlt, osc}, 5'b01100);
      apb(0, `IRT_OFF_CTRL, 0);
      chk(rd, 32'h1103);
      apb(0, 12'h010, 0);
      chk(err, 1);
      chk(rd, 0);
      $display("test reset done");
      for (int i = 0; i < 2; i++) begin
         apb(1, `IRT_OFF_CTRL, tctl[i]);
         apb(1, `IRT_OFF_TIMER, tld[i]);
         wait_ir(1, n);
         wait_cyc(2);
         chk({ind, eoc}, 2'b00);
         wait_ir(0, n);
         chk(n >= texp[i] - 5 && n <= texp[i], 1);
         wait_cyc(2);
         chk({ind, eoc}, 2'b11);
      end
      $display("test interval done");
      apb(1, `IRT_OFF_TIMER, 32'h005);
      wait_cyc(10);
      chk({ir, ind}, 2'b01);
      apb(0, `IRT_OFF_TIMER, 0);
      chk(rd[10], 1);
      apb(1, `IRT_OFF_TIMER, 32'h300);
      wait_cyc(3);
      chk(ir, 1);
      apb(1, `IRT_OFF_TIMER, 32'h000);
      wait_cyc(3);
      chk({ir, eoc}, 2'b01);
      apb(1, `IRT_OFF_TIMER, 32'h20a);
      wait_cyc(100);
      apb(1, `IRT_OFF_TIMER, 32'h201);
      wait_ir(0, n);
      chk(n >= 256 && n <= 260, 1);
      $display("test load done");
      for (int m = 0; m < 5; m++) begin
         apb(1, `IRT_OFF_CTRL, m < 4 ? 32'h100 | m : 32'h108);
         apb(1, `IRT_OFF_TIMER, 32'h214);
         wait_ir(1, n);
         wait_ir(0, n);
         wait_ir(1, n);
         wait_ir(0, n);
         chk(n, chi[m]);
         wait_ir(1, n);
         chk(n, clo[m]);
         apb(1, `IRT_OFF_TIMER, 32'h000);
         wait_cyc(200);
         chk(ir, 0);
      end
      $display("test carrier done");
      apb(1, `IRT_OFF_CTRL, 32'h104);
      apb(1, `IRT_OFF_HOLD, 32'ha5c3);
      apb(1, `IRT_OFF_TIMER, 32'h202);
      apb(1, `IRT_OFF_STBY, 32'h10);
      apb(1, `IRT_OFF_STBY, 32'h01);
      wait_cyc(3);
      chk({hlt, ir}, 2'b11);
      apb(1, `IRT_OFF_HOLD, 32'h1111);
      chk(err, 1);
      n = 0;
      while (hlt !== 0 && n < 400) begin
         @(posedge clock_i);
         n++;
      end
      chk({n < 400, eoc}, 2'b11);
      apb(0, `IRT_OFF_STBY, 0);
      chk(rd[4], 1);
      apb(0, `IRT_OFF_HOLD, 0);
      chk(rd[15:0], 16'ha5c3);
      apb(1, `IRT_OFF_STBY, 32'h01);
      wait_cyc(3);
      chk(hlt, 0);
      apb(1, `IRT_OFF_STBY, 32'h10);
      apb(1, `IRT_OFF_STBY, 32'h01);
      wait_cyc(3);
      apb(0, `IRT_OFF_STBY, 0);
      chk({hlt, rd[4]}, 2'b01);
      $display("test halt done");
      apb(1, `IRT_OFF_STBY, 32'h10);
      apb(1, `IRT_OFF_TIMER, 32'h232);
      apb(1, `IRT_OFF_STBY, 32'h02);
      wait_cyc(3);
      chk({osc, hlt}, 2'b11);
      apb(0, `IRT_OFF_TIMER, 0);
      chk(rd[10:0], 11'h000);
      @(posedge clock_i);
      wake <= 1;
      n = 0;
      while (hlt !== 0 && n < 50) begin
         @(posedge clock_i);
         n++;
      end
      chk({n < 50, osc}, 2'b10);
      wake <= 0;
      apb(0, `IRT_OFF_STBY, 0);
      chk(rd[4], 1);
      chk(pulses > 0, 1);
      $display("test stop done");
      apb(1, `IRT_OFF_CTRL, 32'h004);
      wait_cyc(3);
      chk({ind_oe, ind_pd}, 2'b01);
      apb(0, `IRT_OFF_CTRL, 0);
      chk(rd, 32'h004);
      $display("test pin done");
      summarize();
   end
   initial begin
      #(60000 * 25);
      n_fail++;
      summarize();
   end
endmodule
